// ---- core/cwg_core.sv ----
// complementary waveform generator with dead band, register port
`timescale 1ns/1ns
module cwg_core
  import cwg_pkg::*;
(
  input wire logic mclk_i,
  input wire logic reset_n_i,
  input wire logic [2:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [7:0] rdata_o,
  input wire logic pin_select_input_i,
  input wire logic comparator_one_out_i,
  input wire logic comparator_two_out_i,
  input wire logic [3:0] capture_pwm_i,
  input wire logic [1:0] pwm_i,
  input wire logic osc_out_i,
  input wire logic [3:0] logic_cell_i,
  input wire logic fast_internal_osc_i,
  input wire logic sleep_i,
  output logic osc_keep_on_o,
  output logic out_a_o,
  output logic out_b_o,
  output logic out_c_o,
  output logic out_d_o
);

  ctrl_state_t s;
  ctrl_state_t n;

  logic data;
  logic data_rise;
  logic data_fall;
  logic tick;
  logic is_hb;
  logic is_fb;
  logic want_rev;
  logic dir_switch;
  logic dir_eff;
  logic rise_start;
  logic fall_start;
  logic rise_abort;
  logic fall_abort;
  logic rise_busy;
  logic fall_busy;
  logic rise_gate;
  logic fall_gate;
  logic [3:0] raw;

  // ****************************************
  // helpers
  // ****************************************
  function automatic logic fb_code(input logic [2:0] m);
    fb_code = (m == MODE_FB_FWD) || (m == MODE_FB_REV);
  endfunction

  function automatic logic db_gate(input logic busy, input logic start,
                                   input logic [5:0] limit);
    db_gate = busy || (start && limit != COUNT_ZERO);
  endfunction

  // ****************************************
  // input selection and edges
  // ****************************************
  cwg_source_mux u_mux (
    .mclk_i(mclk_i),
    .reset_n_i(reset_n_i),
    .source_select_i(s.src),
    .pin_select_input_i(pin_select_input_i),
    .comparator_one_out_i(comparator_one_out_i),
    .comparator_two_out_i(comparator_two_out_i),
    .capture_pwm_i(capture_pwm_i),
    .pwm_i(pwm_i),
    .osc_out_i(osc_out_i),
    .logic_cell_i(logic_cell_i),
    .data_o(data)
  );

  assign data_rise = s.en && data && !s.data_prev;
  assign data_fall = s.en && !data && s.data_prev;

  // dead-band tick: system clock stops in sleep, oscillator does not
  assign tick = s.cs ? fast_internal_osc_i : !sleep_i;

  // ****************************************
  // mode decode and dead-band starts
  // ****************************************
  assign is_hb = s.en && (s.mode == MODE_HALF);
  assign is_fb = s.en && fb_code(s.mode);
  assign want_rev = (s.mode == MODE_FB_REV);
  assign dir_switch = is_fb && data_rise && s.dir_known
    && (want_rev != s.dir);
  assign dir_eff = dir_switch ? want_rev : s.dir;

  // half bridge times data edges, full bridge only direction changes
  assign rise_start = is_hb ? data_rise
    : (dir_switch && want_rev);
  assign fall_start = is_hb ? data_fall
    : (dir_switch && !want_rev);
  assign rise_abort = (is_hb && data_fall) || !s.en;
  assign fall_abort = (is_hb && data_rise) || !s.en;

  cwg_deadband u_rise (
    .mclk_i(mclk_i),
    .reset_n_i(reset_n_i),
    .start_i(rise_start),
    .abort_i(rise_abort),
    .tick_i(tick),
    .limit_i(s.rise_work),
    .busy_o(rise_busy)
  );

  cwg_deadband u_fall (
    .mclk_i(mclk_i),
    .reset_n_i(reset_n_i),
    .start_i(fall_start),
    .abort_i(fall_abort),
    .tick_i(tick),
    .limit_i(s.fall_work),
    .busy_o(fall_busy)
  );

  assign rise_gate = db_gate(rise_busy, rise_start, s.rise_work);
  assign fall_gate = db_gate(fall_busy, fall_start, s.fall_work);

  // ****************************************
  // waveform, raw order is {d, c, b, a}
  // ****************************************
  always_comb begin
    raw = 4'h0;
    if (is_hb) begin
      raw[0] = data && !rise_gate;
      raw[1] = !data && !fall_gate;
      raw[2] = raw[0];
      raw[3] = raw[1];
    end else if (is_fb && (s.dir_known || data_rise)) begin
      if (!dir_eff) begin
        raw[0] = 1'b1;
        raw[3] = data && !fall_gate;
      end else begin
        raw[2] = 1'b1;
        raw[1] = data && !rise_gate;
      end
    end
  end

  // ****************************************
  // next state
  // ****************************************
  always_comb begin
    n = s;
    n.rdata = 8'h00;
    n.data_prev = data;
    n.hold = !s.en;
    n.osc_req = s.en && s.cs;

    // direction tracking
    if (!s.en) begin
      n.dir_known = 1'b0;
      n.ld_armed = 1'b0;
    end else if (is_fb && data_rise) begin
      n.dir_known = 1'b1;
      n.dir = want_rev;
    end

    // buffered count transfer while enabled
    if (s.en && s.ld) begin
      if (data_fall) begin
        n.ld_armed = 1'b1;
      end
      if (s.ld_armed && data_rise) begin
        n.rise_work = s.rise_buf;
        n.fall_work = s.fall_buf;
        n.ld = 1'b0;
        n.ld_armed = 1'b0;
      end
    end

    // register writes, a set of the load request beats its clearing
    if (wr_i) begin
      case (addr_i)
        REG_MAIN: begin
          n.en = wdata_i[EN_BIT];
          n.ld = wdata_i[LD_BIT];
          if (!wdata_i[LD_BIT]) begin
            n.ld_armed = 1'b0;
          end
          if (!s.en || (fb_code(s.mode) && fb_code(wdata_i[2:0]))) begin
            n.mode = wdata_i[2:0];
          end
        end
        REG_POL: n.pol = wdata_i[3:0];
        REG_SRC: n.src = wdata_i[3:0];
        REG_RISE: begin
          n.rise_buf = wdata_i[5:0];
          if (!s.en) begin
            n.rise_work = wdata_i[5:0];
          end
        end
        REG_FALL: begin
          n.fall_buf = wdata_i[5:0];
          if (!s.en) begin
            n.fall_work = wdata_i[5:0];
          end
        end
        REG_CLK: n.cs = wdata_i[CS_BIT];
        REG_SHUT: begin
          n.sd = wdata_i[SD_BIT];
          n.ovr_ac = wdata_i[OVR_AC_BIT];
          n.ovr_bd = wdata_i[OVR_BD_BIT];
        end
        default: n.en = s.en;
      endcase
    end

    // register reads, data stand one cycle
    if (rd_i) begin
      case (addr_i)
        REG_MAIN: n.rdata = {s.en, s.ld, 3'h0, s.mode};
        REG_POL: n.rdata = {4'h0, s.pol};
        REG_SRC: n.rdata = {4'h0, s.src};
        REG_RISE: n.rdata = {2'h0, s.rise_buf};
        REG_FALL: n.rdata = {2'h0, s.fall_buf};
        REG_CLK: n.rdata = {7'h00, s.cs};
        REG_SHUT: n.rdata = {5'h00, s.ovr_bd, s.ovr_ac, s.sd};
        REG_STAT: n.rdata = {s.outs, s.dir, rise_busy, fall_busy, s.ld_armed};
        default: n.rdata = 8'h00;
      endcase
    end

    // output stage
    if (!s.en || s.hold) begin
      n.outs = 4'h0;
    end else if (s.sd) begin
      n.outs = {s.ovr_bd, s.ovr_ac, s.ovr_bd, s.ovr_ac};
    end else begin
      n.outs = raw ^ s.pol;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (!reset_n_i) begin
      s <= CTRL_RESET;
    end else begin
      s <= n;
    end
  end

  assign rdata_o = s.rdata;
  assign osc_keep_on_o = s.osc_req;
  assign out_a_o = s.outs[0];
  assign out_b_o = s.outs[1];
  assign out_c_o = s.outs[2];
  assign out_d_o = s.outs[3];

  // ****************************************
  // checks
  // ****************************************
  a_fb_forward_static: assert property (@(posedge mclk_i)
    disable iff (!reset_n_i)
    is_fb && !s.hold && !s.sd && s.dir_known && !dir_switch && !s.dir
    |=> out_a_o == !$past(s.pol[0]) && out_c_o == $past(s.pol[2])
      && out_b_o == $past(s.pol[1]))
    else $error("forward bridge static levels wrong");

  a_fb_reverse_static: assert property (@(posedge mclk_i)
    disable iff (!reset_n_i)
    is_fb && !s.hold && !s.sd && s.dir_known && !dir_switch && s.dir
    |=> out_c_o == !$past(s.pol[2]) && out_a_o == $past(s.pol[0])
      && out_d_o == $past(s.pol[3]))
    else $error("reverse bridge static levels wrong");

  a_dir_on_edge: assert property (@(posedge mclk_i)
    disable iff (!reset_n_i)
    s.en && $past(s.en) && $changed(s.dir)
    |-> $past(data_rise) && $past(is_fb))
    else $error("direction changed without data rise");

  a_rev_resume: assert property (@(posedge mclk_i)
    disable iff (!reset_n_i)
    dir_switch && want_rev && s.rise_work != COUNT_ZERO && !s.sd
      && !s.hold
    |=> out_b_o == $past(s.pol[1]))
    else $error("modulation resumed inside direction dead band");

  a_fwd_resume: assert property (@(posedge mclk_i)
    disable iff (!reset_n_i)
    dir_switch && !want_rev && s.fall_work != COUNT_ZERO && !s.sd
      && !s.hold
    |=> out_d_o == $past(s.pol[3]))
    else $error("d modulated inside direction dead band");

  a_enable_clear: assert property (@(posedge mclk_i)
    disable iff (!reset_n_i)
    $rose(s.en) |=> out_a_o == 1'b0 && out_b_o == 1'b0
      && out_c_o == 1'b0 && out_d_o == 1'b0)
    else $error("outputs not cleared after enable");

  a_override_level: assert property (@(posedge mclk_i)
    disable iff (!reset_n_i)
    s.en && !s.hold && s.sd
    |=> out_a_o == $past(s.ovr_ac) && out_b_o == $past(s.ovr_bd))
    else $error("override level altered by polarity");

  a_hb_rise_hold: assert property (@(posedge mclk_i)
    disable iff (!reset_n_i)
    is_hb && !s.hold && !s.sd && rise_busy
    |=> out_a_o == $past(s.pol[0]))
    else $error("a turned on during rise dead band");

  a_hb_fall_hold: assert property (@(posedge mclk_i)
    disable iff (!reset_n_i)
    is_hb && !s.hold && !s.sd && fall_busy
    |=> out_b_o == $past(s.pol[1]))
    else $error("b turned on during fall dead band");

  a_other_no_band: assert property (@(posedge mclk_i)
    disable iff (!reset_n_i)
    s.en && !is_hb && !is_fb
    |-> !rise_start && !fall_start && !rise_busy && !fall_busy)
    else $error("dead band started outside bridge modes");

  a_load_disabled: assert property (@(posedge mclk_i)
    disable iff (!reset_n_i)
    wr_i && addr_i == REG_RISE && !s.en
    |=> s.rise_work == $past(wdata_i[5:0]))
    else $error("disabled write skipped working count");

  a_load_clear: assert property (@(posedge mclk_i)
    disable iff (!reset_n_i)
    s.en && s.ld && s.ld_armed && data_rise
      && !(wr_i && addr_i == REG_MAIN)
    |=> !s.ld && s.rise_work == $past(s.rise_buf)
      && s.fall_work == $past(s.fall_buf))
    else $error("load request not completed on rising edge");

  a_read_one_cycle: assert property (@(posedge mclk_i)
    disable iff (!reset_n_i)
    !rd_i |=> rdata_o == 8'h00)
    else $error("read data stood beyond one cycle");

endmodule // cwg_core

// ---- core/cwg_pkg.sv ----
// constants and state types for the complementary waveform generator
package cwg_pkg;

  // ****************************************
  // register map
  // ****************************************
  localparam logic [2:0] REG_MAIN = 3'h0;
  localparam logic [2:0] REG_POL = 3'h1;
  localparam logic [2:0] REG_SRC = 3'h2;
  localparam logic [2:0] REG_RISE = 3'h3;
  localparam logic [2:0] REG_FALL = 3'h4;
  localparam logic [2:0] REG_CLK = 3'h5;
  localparam logic [2:0] REG_SHUT = 3'h6;
  localparam logic [2:0] REG_STAT = 3'h7;
  localparam int EN_BIT = 7;
  localparam int LD_BIT = 6;
  localparam int SD_BIT = 0;
  localparam int OVR_AC_BIT = 1;
  localparam int OVR_BD_BIT = 2;
  localparam int CS_BIT = 0;
  localparam logic [5:0] COUNT_ZERO = 6'h00;

  // ****************************************
  // modes and sources
  // ****************************************
  typedef enum logic [2:0] {
    MODE_ASYNC_STEER = 3'b000,
    MODE_SYNC_STEER = 3'b001,
    MODE_FB_FWD = 3'b010,
    MODE_FB_REV = 3'b011,
    MODE_HALF = 3'b100,
    MODE_PUSH_PULL = 3'b101
  } mode_t;

  localparam logic [3:0] SRC_PIN = 4'h0;
  localparam logic [3:0] SRC_CMP1 = 4'h1;
  localparam logic [3:0] SRC_CMP2 = 4'h2;
  localparam logic [3:0] SRC_CCP1 = 4'h3;
  localparam logic [3:0] SRC_CCP2 = 4'h4;
  localparam logic [3:0] SRC_CCP3 = 4'h5;
  localparam logic [3:0] SRC_CCP4 = 4'h6;
  localparam logic [3:0] SRC_PWM1 = 4'h7;
  localparam logic [3:0] SRC_PWM2 = 4'h8;
  localparam logic [3:0] SRC_OSC = 4'h9;
  localparam logic [3:0] SRC_LC1 = 4'hA;
  localparam logic [3:0] SRC_LC2 = 4'hB;
  localparam logic [3:0] SRC_LC3 = 4'hC;
  localparam logic [3:0] SRC_LC4 = 4'hD;

  // ****************************************
  // state types
  // ****************************************
  typedef enum logic {DB_IDLE = 1'b0, DB_COUNT = 1'b1} db_phase_t;

  typedef struct packed {
    db_phase_t phase;
    logic [5:0] cnt;
  } db_state_t;

  localparam db_state_t DB_RESET = '{phase: DB_IDLE, cnt: 6'h00};

  typedef struct packed {
    logic en;
    logic ld;
    logic ld_armed;
    logic [2:0] mode;
    logic [3:0] pol;
    logic [3:0] src;
    logic [5:0] rise_buf;
    logic [5:0] fall_buf;
    logic [5:0] rise_work;
    logic [5:0] fall_work;
    logic cs;
    logic sd;
    logic ovr_ac;
    logic ovr_bd;
    logic dir;
    logic dir_known;
    logic hold;
    logic data_prev;
    logic osc_req;
    logic [3:0] outs;
    logic [7:0] rdata;
  } ctrl_state_t;

  localparam ctrl_state_t CTRL_RESET = '{
    en: 1'b0, ld: 1'b0, ld_armed: 1'b0, mode: 3'h0, pol: 4'h0,
    src: 4'h0, rise_buf: 6'h00, fall_buf: 6'h00, rise_work: 6'h00,
    fall_work: 6'h00, cs: 1'b0, sd: 1'b0, ovr_ac: 1'b0, ovr_bd: 1'b0,
    dir: 1'b0, dir_known: 1'b0, hold: 1'b1, data_prev: 1'b0,
    osc_req: 1'b0, outs: 4'h0, rdata: 8'h00};

endpackage

// ---- core/cwg_source_mux.sv ----
// data input selector of the waveform generator
`timescale 1ns/1ns
module cwg_source_mux
  import cwg_pkg::*;
(
  input wire logic mclk_i,
  input wire logic reset_n_i,
  input wire logic [3:0] source_select_i,
  input wire logic pin_select_input_i,
  input wire logic comparator_one_out_i,
  input wire logic comparator_two_out_i,
  input wire logic [3:0] capture_pwm_i,
  input wire logic [1:0] pwm_i,
  input wire logic osc_out_i,
  input wire logic [3:0] logic_cell_i,
  output logic data_o
);

  logic s;
  logic n;

  // ****************************************
  // source selection
  // ****************************************
  always_comb begin
    case (source_select_i)
      SRC_PIN: n = pin_select_input_i;
      SRC_CMP1: n = comparator_one_out_i;
      SRC_CMP2: n = comparator_two_out_i;
      SRC_CCP1: n = capture_pwm_i[0];
      SRC_CCP2: n = capture_pwm_i[1];
      SRC_CCP3: n = capture_pwm_i[2];
      SRC_CCP4: n = capture_pwm_i[3];
      SRC_PWM1: n = pwm_i[0];
      SRC_PWM2: n = pwm_i[1];
      SRC_OSC: n = osc_out_i;
      SRC_LC1: n = logic_cell_i[0];
      SRC_LC2: n = logic_cell_i[1];
      SRC_LC3: n = logic_cell_i[2];
      SRC_LC4: n = logic_cell_i[3];
      default: n = 1'b0;
    endcase
  end

  always_ff @(posedge mclk_i) begin
    if (!reset_n_i) begin
      s <= 1'b0;
    end else begin
      s <= n;
    end
  end

  assign data_o = s;

endmodule // cwg_source_mux

// ---- core/cwg_deadband.sv ----
// one 6-bit dead-band counter
`timescale 1ns/1ns
module cwg_deadband
  import cwg_pkg::*;
(
  input wire logic mclk_i,
  input wire logic reset_n_i,
  input wire logic start_i,
  input wire logic abort_i,
  input wire logic tick_i,
  input wire logic [5:0] limit_i,
  output logic busy_o
);

  db_state_t s;
  db_state_t n;

  // ****************************************
  // counter
  // ****************************************
  always_comb begin
    n = s;
    case (s.phase)
      DB_IDLE: begin
        if (start_i && limit_i != COUNT_ZERO) begin
          n.phase = DB_COUNT;
          n.cnt = COUNT_ZERO;
        end
      end
      DB_COUNT: begin
        if (abort_i) begin
          n.phase = DB_IDLE;
        end else if (start_i) begin
          n.phase = (limit_i != COUNT_ZERO) ? DB_COUNT : DB_IDLE;
          n.cnt = COUNT_ZERO;
        end else if (tick_i) begin
          if (s.cnt + 6'h01 >= limit_i) begin
            n.phase = DB_IDLE;
          end else begin
            n.cnt = s.cnt + 6'h01;
          end
        end
      end
      default: n = DB_RESET;
    endcase
  end

  always_ff @(posedge mclk_i) begin
    if (!reset_n_i) begin
      s <= DB_RESET;
    end else begin
      s <= n;
    end
  end

  assign busy_o = (s.phase == DB_COUNT);

  a_zero_count: assert property (@(posedge mclk_i)
    disable iff (!reset_n_i)
    start_i && !abort_i && limit_i == COUNT_ZERO |=> !busy_o)
    else $error("zero dead-band count started a delay");

  a_count_step: assert property (@(posedge mclk_i)
    disable iff (!reset_n_i)
    busy_o && tick_i && !abort_i && !start_i
      && (s.cnt + 6'h01 < limit_i)
    |=> busy_o && s.cnt == $past(s.cnt) + 6'h01)
    else $error("dead-band counter failed to step");

endmodule // cwg_deadband

// ---- tb/bridge_switches.sv ----
// model of the external bridge switches and their drivers
`timescale 1ns/1ns
module bridge_switches (
  input wire logic mclk_i,
  input wire logic [3:0] drive_i,
  input wire logic [3:0] pol_i,
  output logic shoot_o
);
  logic [3:0] sw_on;

  // ****************************************
  // switch legs
  // ****************************************
  // a switch conducts when its drive is at the active level
  assign sw_on = drive_i ^ pol_i;

  // a and b share one leg, c and d the other
  always_ff @(posedge mclk_i) begin
    shoot_o <= (sw_on[0] & sw_on[1]) | (sw_on[2] & sw_on[3]);
  end
endmodule // bridge_switches

// ---- tb/testbench.sv ----
// self-checking bench for the waveform generator core
`timescale 1ns/1ns
module testbench;
  import cwg_pkg::*;
  logic mclk_i = 1'b0;
  logic reset_n_i = 1'b0;
  logic [2:0] addr_i = 3'h0;
  logic [7:0] wdata_i = 8'h00;
  logic wr_i = 1'b0;
  logic rd_i = 1'b0;
  logic [13:0] src = 14'h0000;
  logic tick = 1'b0;
  logic sleep = 1'b0;
  logic watch = 1'b0;
  logic [3:0] pol = 4'h0;
  logic [2:0] div = 3'h0;
  logic [7:0] rdata_o;
  logic osc_keep;
  logic [3:0] outs;
  logic shoot;
  logic [5:0] rtab [3] = '{6'h00, 6'h03, 6'h3F};
  logic [5:0] ftab [3] = '{6'h00, 6'h07, 6'h01};
  int num_errors = 0;
  int checks_done = 0;
  int d = 0;
  int n = 0;

  // ****************************************
  // clock, oscillator ticks, design
  // ****************************************
  always #5 mclk_i = ~mclk_i;

  // one tick every six cycles, close to 16 MHz
  always @(posedge mclk_i) begin
    div <= (div == 3'h5) ? 3'h0 : div + 3'h1;
    tick <= (div == 3'h5);
  end

  cwg_core dut_u (
    .mclk_i(mclk_i), .reset_n_i(reset_n_i), .addr_i(addr_i),
    .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
    .pin_select_input_i(src[0]), .comparator_one_out_i(src[1]),
    .comparator_two_out_i(src[2]), .capture_pwm_i(src[6:3]),
    .pwm_i(src[8:7]), .osc_out_i(src[9]), .logic_cell_i(src[13:10]),
    .fast_internal_osc_i(tick), .sleep_i(sleep),
    .osc_keep_on_o(osc_keep), .out_a_o(outs[0]), .out_b_o(outs[1]),
    .out_c_o(outs[2]), .out_d_o(outs[3])
  );

  bridge_switches drv_u (
    .mclk_i(mclk_i), .drive_i(outs), .pol_i(pol), .shoot_o(shoot)
  );

  // ****************************************
  // tasks
  // ****************************************
  task check(input logic [7:0] seen, input logic [7:0] exp);
    checks_done++;
    if (seen !== exp) begin
      num_errors++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task results();
    $display("checks %0d mismatches %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  task wr_reg(input logic [2:0] ad, input logic [7:0] dt);
    @(posedge mclk_i);
    addr_i <= ad;
    wdata_i <= dt;
    wr_i <= 1'b1;
    @(posedge mclk_i);
    wr_i <= 1'b0;
    if (ad == REG_POL) pol <= dt[3:0];
  endtask

  task rd_reg(input logic [2:0] ad, input logic [7:0] exp);
    @(posedge mclk_i);
    addr_i <= ad;
    rd_i <= 1'b1;
    @(posedge mclk_i);
    rd_i <= 1'b0;
    #1 check(rdata_o, exp);
  endtask

  task cyc(input int k);
    repeat (k) @(posedge mclk_i);
  endtask

  task drive(input logic v);
    @(posedge mclk_i);
    src[0] <= v;
    d = 0;
  endtask

  // counts edges since the last source change until an output settles
  task wait_out(input int k, input logic lvl);
    do begin
      @(posedge mclk_i);
      #1 d++;
    end while (outs[k] !== lvl && d < 1000);
  endtask

  task in_range(input int lo, input int hi);
    check({7'h00, (d >= lo && d <= hi)}, 8'h01);
  endtask

  // loads counts while disabled, then enables in the given mode
  task setup(input logic [2:0] m, input logic [5:0] r, input logic [5:0] f);
    wr_reg(REG_MAIN, {5'h00, m});
    wr_reg(REG_RISE, {2'h0, r});
    wr_reg(REG_FALL, {2'h0, f});
    wr_reg(REG_MAIN, {5'h10, m});
    cyc(4);
  endtask

  always @(posedge mclk_i) begin
    if (watch) check({7'h00, shoot}, 8'h00);
  end

  // ****************************************
  // tests
  // ****************************************
  initial begin
    repeat (30000) @(posedge mclk_i);
    num_errors++;
    results();
  end

  initial begin
    repeat (6) @(posedge mclk_i);
    reset_n_i <= 1'b1;
    wr_reg(REG_POL, 8'h05);
    rd_reg(REG_POL, 8'h05);
    wr_reg(REG_SRC, 8'h0D);
    rd_reg(REG_SRC, 8'h0D);
    wr_reg(REG_RISE, 8'h3F);
    rd_reg(REG_RISE, 8'h3F);
    wr_reg(REG_POL, 8'h00);
    wr_reg(REG_STAT, 8'hFF);
    rd_reg(REG_STAT, 8'h00);
    $display("test registers done");
    wr_reg(REG_SRC, 8'h00);
    wr_reg(REG_RISE, 8'h00);
    wr_reg(REG_FALL, 8'h00);
    src[0] <= 1'b1;
    cyc(3);
    wr_reg(REG_MAIN, 8'h84);
    #1 check(outs, 4'h0);
    @(posedge mclk_i);
    #1 check(outs, 4'h0);
    cyc(3);
    #1 check(outs, 4'h5);
    $display("test enable done");
    for (n = 0; n < 16; n++) begin
      wr_reg(REG_SRC, n[7:0]);
      src <= (n < 14) ? 14'h0001 << n : 14'h3FFF;
      cyc(5);
      #1 check(outs, (n < 14) ? 8'h05 : 8'h0A);
      @(posedge mclk_i);
      src <= 14'h0000;
      cyc(5);
      #1 check(outs, 8'h0A);
    end
    wr_reg(REG_SRC, 8'h00);
    $display("test source done");
    watch <= 1'b1;
    for (n = 0; n < 3; n++) begin
      setup(MODE_HALF, rtab[n], ftab[n]);
      drive(1'b1);
      wait_out(0, 1'b1);
      in_range(rtab[n] + 2, rtab[n] + 3);
      cyc(70);
      drive(1'b0);
      wait_out(1, 1'b1);
      in_range(ftab[n] + 2, ftab[n] + 3);
      cyc(70);
    end
    setup(MODE_HALF, 6'h0A, 6'h00);
    drive(1'b1);
    cyc(4);
    drive(1'b0);
    repeat (20) begin
      @(posedge mclk_i);
      #1 if (outs[0] !== 1'b0) d++;
    end
    check(d[7:0], 8'h00);
    watch <= 1'b0;
    $display("test deadband done");
    wr_reg(REG_MAIN, 8'h04);
    wr_reg(REG_CLK, 8'h01);
    setup(MODE_HALF, 6'h03, 6'h00);
    sleep <= 1'b1;
    #1 check(osc_keep, 1'b1);
    drive(1'b1);
    wait_out(0, 1'b1);
    in_range(14, 22);
    drive(1'b0);
    cyc(30);
    sleep <= 1'b0;
    wr_reg(REG_CLK, 8'h00);
    cyc(2);
    #1 check(osc_keep, 1'b0);
    // system-clock ticks stop in sleep, the band waits for wake-up
    drive(1'b1);
    sleep <= 1'b1;
    cyc(10);
    sleep <= 1'b0;
    #1 check(outs, 8'h00);
    wait_out(0, 1'b1);
    in_range(4, 5);
    drive(1'b0);
    $display("test clock done");
    setup(MODE_HALF, 6'h00, 6'h00);
    wr_reg(REG_POL, 8'h0F);
    cyc(2);
    #1 check(outs, 8'h05);
    wr_reg(REG_SHUT, 8'h03);
    cyc(2);
    #1 check(outs, 8'h05);
    wr_reg(REG_POL, 8'h00);
    cyc(2);
    #1 check(outs, 8'h05);
    wr_reg(REG_SHUT, 8'h00);
    cyc(2);
    #1 check(outs, 8'h0A);
    setup(MODE_PUSH_PULL, 6'h00, 6'h00);
    drive(1'b1);
    cyc(5);
    #1 check(outs, 8'h00);
    drive(1'b0);
    $display("test polarity done");
    setup(MODE_FB_FWD, 6'h05, 6'h04);
    #1 check(outs, 8'h00);
    drive(1'b1);
    cyc(4);
    #1 check(outs, 8'h09);
    drive(1'b0);
    cyc(4);
    #1 check(outs, 8'h01);
    wr_reg(REG_MAIN, 8'h83);
    rd_reg(REG_MAIN, 8'h83);
    cyc(4);
    #1 check(outs, 8'h01);
    drive(1'b1);
    wait_out(2, 1'b1);
    in_range(2, 3);
    check(outs, 8'h04);
    wait_out(1, 1'b1);
    in_range(7, 8);
    check(outs, 8'h06);
    wr_reg(REG_MAIN, 8'h84);
    rd_reg(REG_MAIN, 8'h83);
    drive(1'b0);
    cyc(4);
    wr_reg(REG_MAIN, 8'h82);
    drive(1'b1);
    wait_out(0, 1'b1);
    in_range(2, 3);
    check(outs, 8'h01);
    wait_out(3, 1'b1);
    in_range(6, 7);
    drive(1'b0);
    $display("test bridge done");
    setup(MODE_HALF, 6'h02, 6'h00);
    drive(1'b1);
    wait_out(0, 1'b1);
    in_range(4, 5);
    drive(1'b0);
    cyc(10);
    wr_reg(REG_RISE, 8'h08);
    drive(1'b1);
    wait_out(0, 1'b1);
    in_range(4, 5);
    wr_reg(REG_MAIN, 8'hC4);
    rd_reg(REG_MAIN, 8'hC4);
    drive(1'b0);
    cyc(10);
    drive(1'b1);
    cyc(15);
    rd_reg(REG_MAIN, 8'h84);
    drive(1'b0);
    cyc(10);
    drive(1'b1);
    wait_out(0, 1'b1);
    in_range(10, 11);
    $display("test load done");
    results();
  end
endmodule // testbench
